/* pwt_pkg.sv */
// constants shared by the power-enable and wake-timer block
package pwt_pkg;

    // clock and wake-interval timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned WAKE_UNIT_NS  = 1030000;  // 1.03 ms per unit
    localparam int unsigned WAKE_OFFS_NS  = 500000;   // 0.5 ms fixed part
    localparam int unsigned WAKE_UNIT_CYC = WAKE_UNIT_NS / CLK_PERIOD_NS;
    localparam int unsigned WAKE_OFFS_CYC = WAKE_OFFS_NS / CLK_PERIOD_NS;

    // register byte offsets on the bus
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_POWER  = 8'h04;
    localparam logic [7:0] ADDR_WAKE   = 8'h08;
    localparam logic [7:0] ADDR_STAT   = 8'h0c;
    localparam logic [7:0] ADDR_CLR    = 8'h10;
    localparam logic [7:0] ADDR_IEN    = 8'h14;
    localparam logic [7:0] ADDR_STATE  = 8'h18;
    localparam logic [7:0] ADDR_BATT   = 8'h1c;

    // command decode
    localparam logic [7:0] CMD_PWR_SEL  = 8'h82;
    localparam logic [2:0] CMD_WAKE_SEL = 3'h7;

    // power word field positions
    localparam int unsigned PWR_RX_BIT   = 7;
    localparam int unsigned PWR_BB_BIT   = 6;
    localparam int unsigned PWR_TX_BIT   = 5;
    localparam int unsigned PWR_SYN_BIT  = 4;
    localparam int unsigned PWR_OSC_BIT  = 3;
    localparam int unsigned PWR_BAT_BIT  = 2;
    localparam int unsigned PWR_WAKE_BIT = 1;
    localparam int unsigned PWR_CLKO_BIT = 0;

    // wake setting field positions
    localparam int unsigned WAKE_EXP_LSB = 8;
    localparam int unsigned WAKE_EXP_W   = 5;
    localparam int unsigned WAKE_MUL_W   = 8;

    // status bits
    localparam int unsigned STAT_WAKE_BIT = 0;

    // reset values
    localparam logic [15:0] PWR_RST  = 16'h8208;
    localparam logic [15:0] WAKE_RST = 16'he196;
    localparam logic [4:0]  BATT_RST = 5'h00;
    localparam logic [0:0]  STAT_RST = 1'h0;
    localparam logic [0:0]  IEN_RST  = 1'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* pwt_wake_timer.sv */
// wake-up interval timer: offset phase, then multiplier << exponent units
`timescale 1ns/1ps

module pwt_wake_timer
    import pwt_pkg::*;
#(
    parameter int unsigned UNIT_CYC = WAKE_UNIT_CYC,
    parameter int unsigned OFFS_CYC = WAKE_OFFS_CYC,
    parameter int unsigned CNT_W    = 24
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  arm_en,
    input  wire logic [WAKE_EXP_W-1:0] exponent,
    input  wire logic [WAKE_MUL_W-1:0] multiplier,
    output logic                       expire,
    output logic                       busy
);

    typedef enum logic [1:0] {
        TM_IDLE  = 2'b00,
        TM_OFFS  = 2'b01,
        TM_UNITS = 2'b10,
        TM_DONE  = 2'b11
    } pwt_tstate_e;

    localparam int unsigned TGT_W = WAKE_MUL_W + 32;

    pwt_tstate_e        state_q, state_d;
    logic [CNT_W-1:0]   cyc_q, cyc_d;
    logic [TGT_W-1:0]   unit_q, unit_d;
    logic [TGT_W-1:0]   tgt_q, tgt_d;
    logic               exp_d, exp_q;

    // next state: arming only from idle, so a finished timer waits for
    // the enable to drop and rise again before counting anew
    always_comb begin
        state_d = state_q;
        cyc_d   = cyc_q;
        unit_d  = unit_q;
        tgt_d   = tgt_q;
        exp_d   = 1'b0;
        if (!arm_en) begin
            state_d = TM_IDLE;
        end else begin
            case (state_q)
                TM_IDLE: begin
                    state_d = TM_OFFS;
                    cyc_d   = '0;
                    unit_d  = '0;
                    // interval units = multiplier * 2^exponent
                    tgt_d   = TGT_W'({32'h0000_0000, multiplier}
                              << exponent);
                end
                TM_OFFS: begin
                    if (cyc_q == CNT_W'(OFFS_CYC - 1)) begin
                        cyc_d = '0;
                        if (tgt_q == '0) begin
                            state_d = TM_DONE;
                            exp_d   = 1'b1;
                        end else begin
                            state_d = TM_UNITS;
                        end
                    end else begin
                        cyc_d = cyc_q + 1'b1;
                    end
                end
                TM_UNITS: begin
                    if (cyc_q == CNT_W'(UNIT_CYC - 1)) begin
                        cyc_d  = '0;
                        unit_d = unit_q + 1'b1;
                        if (unit_q + 1'b1 == tgt_q) begin
                            state_d = TM_DONE;
                            exp_d   = 1'b1;
                        end
                    end else begin
                        cyc_d = cyc_q + 1'b1;
                    end
                end
                TM_DONE: begin
                    state_d = TM_DONE;
                end
                default: begin
                    state_d = TM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= TM_IDLE;
            cyc_q   <= '0;
            unit_q  <= '0;
            tgt_q   <= '0;
            exp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cyc_q   <= cyc_d;
            unit_q  <= unit_d;
            tgt_q   <= tgt_d;
            exp_q   <= exp_d;
        end
    end

    assign expire = exp_q;
    assign busy   = (state_q == TM_OFFS) || (state_q == TM_UNITS);

    // offset phase lasts exactly the offset count
    a_offset_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == TM_OFFS && state_d != TM_OFFS && arm_en)
        |-> cyc_q == CNT_W'(OFFS_CYC - 1))
        else $error("offset phase wrong length");

    // expiry stops the timer until re-armed
    a_expire_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (expire && arm_en) |=> !expire && !busy)
        else $error("timer ran on after expiry");

    // dropping the enable stops the count
    a_enable_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !arm_en |=> !busy && !expire)
        else $error("timer active while disabled");

endmodule

/* pwt_top.sv */
// power-enable word, wake timer settings and axi4-lite register slave
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

module pwt_top
    import pwt_pkg::*;
#(
    parameter int unsigned UNIT_CYC = WAKE_UNIT_CYC,
    parameter int unsigned OFFS_CYC = WAKE_OFFS_CYC,
    parameter int unsigned ADDR_W   = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   rx_chain_on,
    output logic                   baseband_on,
    output logic                   tx_chain_on,
    output logic                   synth_on,
    output logic                   xtal_osc_on,
    output logic                   battery_detect_on,
    output logic [4:0]             battery_threshold,
    output logic                   wake_timer_on,
    output logic                   clock_out_en,
    output logic                   full_sleep,
    output logic                   wake_event,
    output logic                   irq
);

    // reset release synchroniser
    logic rst_s1_q, rst_s2_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    logic rst_n;
    assign rst_n = rst_s2_q;

    // address decode, shared by read and write paths
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] off);
        return a[7:0] == off;
    endfunction

    // axi write channel holding state
    logic              aw_hold_q, aw_hold_d;
    logic              w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0]       w_data_q, w_data_d;
    logic [3:0]        w_strb_q, w_strb_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              wr_go;
    logic              wr_hit;

    // both halves must be held before a write commits
    assign wr_go  = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_hit = addr_is(aw_addr_q, ADDR_CMD)
                 || addr_is(aw_addr_q, ADDR_CLR)
                 || addr_is(aw_addr_q, ADDR_IEN)
                 || addr_is(aw_addr_q, ADDR_BATT);

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        aw_addr_d = aw_addr_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // command decode; a partial strobe on the low half is ignored
    logic        cmd_wr, pwr_cmd, wake_cmd;
    logic [15:0] cmd_word;
    assign cmd_word = w_data_q[15:0];
    assign cmd_wr   = wr_go && addr_is(aw_addr_q, ADDR_CMD)
                   && (w_strb_q[1:0] == 2'b11);
    assign pwr_cmd  = cmd_wr && (cmd_word[15:8] == CMD_PWR_SEL);
    assign wake_cmd = cmd_wr && (cmd_word[15:13] == CMD_WAKE_SEL);

    // configuration and interrupt state
    logic [15:0] power_q, power_d;
    logic [15:0] wake_q, wake_d;
    logic [4:0]  batt_q, batt_d;
    logic [0:0]  stat_q, stat_d;
    logic [0:0]  ien_q, ien_d;
    logic        expire, busy;

    // a wake expiry in the same cycle as its clear stays set
    always_comb begin
        power_d = power_q;
        wake_d  = wake_q;
        batt_d  = batt_q;
        ien_d   = ien_q;
        stat_d  = stat_q;
        if (pwr_cmd) begin
            power_d = {CMD_PWR_SEL, cmd_word[7:0]};
        end
        if (wake_cmd) begin
            wake_d = cmd_word;
        end
        if (wr_go && addr_is(aw_addr_q, ADDR_BATT) && w_strb_q[0]) begin
            batt_d = w_data_q[4:0];
        end
        if (wr_go && addr_is(aw_addr_q, ADDR_IEN) && w_strb_q[0]) begin
            ien_d = w_data_q[0:0];
        end
        if (wr_go && addr_is(aw_addr_q, ADDR_CLR) && w_strb_q[0]) begin
            stat_d = stat_q & ~w_data_q[0:0];
        end
        if (expire) begin
            stat_d[STAT_WAKE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            power_q <= PWR_RST;
            wake_q  <= WAKE_RST;
            batt_q  <= BATT_RST;
            stat_q  <= STAT_RST;
            ien_q   <= IEN_RST;
        end else begin
            power_q <= power_d;
            wake_q  <= wake_d;
            batt_q  <= batt_d;
            stat_q  <= stat_d;
            ien_q   <= ien_d;
        end
    end

    // circuit enables; the receive chain pulls in its own parts
    assign rx_chain_on       = power_q[PWR_RX_BIT];
    assign baseband_on       = power_q[PWR_BB_BIT]
                            || power_q[PWR_RX_BIT];
    assign tx_chain_on       = power_q[PWR_TX_BIT];
    assign synth_on          = power_q[PWR_SYN_BIT]
                            || power_q[PWR_RX_BIT];
    assign clock_out_en      = !power_q[PWR_CLKO_BIT];
    // running clock output keeps the oscillator alive
    assign xtal_osc_on       = power_q[PWR_OSC_BIT] || rx_chain_on
                            || clock_out_en;
    assign battery_detect_on = power_q[PWR_BAT_BIT];
    assign battery_threshold = batt_q;
    assign wake_timer_on     = power_q[PWR_WAKE_BIT];
    assign full_sleep        = !xtal_osc_on && !baseband_on && !synth_on
                            && !tx_chain_on && !clock_out_en;
    assign wake_event        = stat_q[STAT_WAKE_BIT];
    assign irq               = |(stat_q & ien_q);

    // wake interval counter; exponent above 29 is the host's fault
    pwt_wake_timer #(
        .UNIT_CYC (UNIT_CYC),
        .OFFS_CYC (OFFS_CYC),
        .CNT_W    (24)
    ) u_timer (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .arm_en     (wake_timer_on),
        .exponent   (wake_q[WAKE_EXP_LSB +: WAKE_EXP_W]),
        .multiplier (wake_q[WAKE_MUL_W-1:0]),
        .expire     (expire),
        .busy       (busy)
    );

    // axi read path: one beat, registered data
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            if (addr_is(s_axi_araddr, ADDR_POWER)) begin
                rdata_d[15:0] = power_q;
            end else if (addr_is(s_axi_araddr, ADDR_WAKE)) begin
                rdata_d[15:0] = wake_q;
            end else if (addr_is(s_axi_araddr, ADDR_STAT)) begin
                rdata_d[0:0] = stat_q;
            end else if (addr_is(s_axi_araddr, ADDR_IEN)) begin
                rdata_d[0:0] = ien_q;
            end else if (addr_is(s_axi_araddr, ADDR_STATE)) begin
                rdata_d[2:0] = {full_sleep, xtal_osc_on, busy};
            end else if (addr_is(s_axi_araddr, ADDR_BATT)) begin
                rdata_d[4:0] = batt_q;
            end else if (!addr_is(s_axi_araddr, ADDR_CMD)
                      && !addr_is(s_axi_araddr, ADDR_CLR)) begin
                rresp_d = RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    a_rx_pulls_parts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_chain_on |-> baseband_on && synth_on && xtal_osc_on)
        else $error("receive chain part unpowered");

    a_bb_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pwr_cmd |=> baseband_on == ($past(cmd_word[7])
                    || $past(cmd_word[6])))
        else $error("baseband enable wrong after write");

    a_synth_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pwr_cmd && cmd_word[4]) |=> synth_on)
        else $error("synthesizer not enabled");

    a_osc_off_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pwr_cmd && cmd_word[7:0] == 8'h01) |=> !xtal_osc_on)
        else $error("oscillator not released");

    a_batt_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pwr_cmd |=> battery_detect_on == $past(cmd_word[2]))
        else $error("battery detector enable wrong");

    a_wake_en_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pwr_cmd |=> wake_timer_on == $past(cmd_word[1]))
        else $error("wake timer enable wrong");

    a_clkout_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pwr_cmd |=> clock_out_en == !$past(cmd_word[0]))
        else $error("clock output polarity wrong");

    a_reset_clkout: assert property (@(posedge clk_sys)
        $rose(rst_n) |-> clock_out_en && power_q == PWR_RST)
        else $error("clock output off after reset");

    a_clkout_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clock_out_en |-> xtal_osc_on && !full_sleep)
        else $error("oscillator stopped with clock out");

    a_wake_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wake_cmd |=> wake_q == $past(cmd_word))
        else $error("wake settings not loaded");

    a_power_whole: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pwr_cmd |=> power_q[7:0] == $past(cmd_word[7:0]))
        else $error("power word not replaced whole");

    a_event_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        expire |=> wake_event)
        else $error("wake event lost");

endmodule

/* pwt_host_model.sv */
// host model: axi4-lite master writing commands and reading back
`timescale 1ns/1ps
module pwt_host_model
    import pwt_pkg::*;
(
    input  wire logic        clk_sys,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // bus idle from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    end
    // each half released only at its own handshake edge; handshakes are
    // judged at the falling edge, where the slave outputs have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (!b_ok);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ar_ok, r_ok;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end while (!r_ok);
        s_axi_rready <= 1'b0;
    endtask
    // host never sends an exponent above 29
    task automatic set_wake(input int e, input int m);
        logic [1:0] r;
        if (e > 29) e = 29;
        wr(ADDR_CMD, {16'h0000, 3'b111, e[4:0], m[7:0]}, r);
    endtask
    // timer enable dropped then raised again to arm the next interval
    task automatic arm(input logic [7:0] pw);
        logic [1:0] r;
        wr(ADDR_CMD, {16'h0000, CMD_PWR_SEL, pw & 8'hfd}, r);
        wr(ADDR_CMD, {16'h0000, CMD_PWR_SEL, pw | 8'h02}, r);
    endtask
endmodule

/* tb_power_enable_and_wakeup_timer.sv */
// testbench for the power-enable word and wake timer block
`timescale 1ns/1ps
module tb_power_enable_and_wakeup_timer;
    import pwt_pkg::*;
    logic        clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq, wake_event;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, b;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        rx_chain_on, baseband_on, tx_chain_on, synth_on, xtal_osc_on;
    logic        battery_detect_on, wake_timer_on, clock_out_en, full_sleep;
    logic [4:0]  battery_threshold;
    logic [8:0]  pwr_seen;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          n;
    assign pwr_seen = {rx_chain_on, baseband_on, tx_chain_on, synth_on,
        xtal_osc_on, battery_detect_on, wake_timer_on, clock_out_en, full_sleep};
    // short wake unit and offset keep the run brief
    pwt_top #(.UNIT_CYC(4), .OFFS_CYC(3)) dut (.clk_sys, .rstn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_chain_on, .baseband_on, .tx_chain_on, .synth_on,
        .xtal_osc_on, .battery_detect_on, .battery_threshold, .wake_timer_on,
        .clock_out_en, .full_sleep, .wake_event, .irq);
    pwt_host_model host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // expected enables; receive chain and clock output pull others on
    function automatic logic [8:0] pwr_exp(input logic [7:0] w);
        logic clk, osc, bb, syn;
        clk = !w[0];
        osc = w[3] | w[7] | clk;
        bb = w[6] | w[7];
        syn = w[4] | w[7];
        return {w[7], bb, w[5], syn, osc, w[2], w[1], clk,
                !(osc | bb | syn | w[5] | clk)};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ev(input int lim);
        n = 0;
        while (wake_event !== 1'b1 && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        summarize();
    end
    initial begin
        rstn = 1'b0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host.rd(ADDR_POWER, rdv, rsp);
        chk(rdv, 32'(PWR_RST));
        chk(32'(pwr_seen), 32'(pwr_exp(8'h08)));
        host.rd(ADDR_WAKE, rdv, rsp);
        chk(rdv, 32'h0000_e196);
        $display("test reset done");
        // each power bit alone, then none (clock output keeps oscillator)
        for (int i = 0; i <= 8; i++) begin
            b = (i == 8) ? 8'h00 : 8'(1 << i);
            host.wr(ADDR_CMD, {16'h0000, CMD_PWR_SEL, b}, rsp);
            host.rd(ADDR_POWER, rdv, rsp);
            chk(rdv, {16'h0000, CMD_PWR_SEL, b});
            chk(32'(pwr_seen), 32'(pwr_exp(b)));
        end
        $display("test power bits done");
        host.wr(ADDR_IEN, 32'h1, rsp);
        host.set_wake(2, 3);
        host.rd(ADDR_WAKE, rdv, rsp);
        chk(rdv, 32'h0000_e203);
        host.arm(8'h01);
        repeat (40) @(negedge clk_sys);
        chk(32'(wake_event), 32'h0);
        host.rd(ADDR_STATE, rdv, rsp);
        chk(rdv, 32'h0000_0005);
        wait_ev(40);
        chk(32'({wake_event, irq}), 32'h3);
        host.rd(ADDR_STAT, rdv, rsp);
        chk(rdv, 32'h1);
        host.wr(ADDR_CLR, 32'h1, rsp);
        repeat (150) @(negedge clk_sys);
        chk(32'({wake_event, irq}), 32'h0);
        // zero multiplier leaves only the offset; interrupt masked
        host.wr(ADDR_IEN, 32'h0, rsp);
        host.set_wake(5, 0);
        host.arm(8'h01);
        wait_ev(15);
        chk(32'({wake_event, irq}), 32'h2);
        $display("test wake timer done");
        host.wr(ADDR_BATT, 32'h3f, rsp);
        chk(32'(battery_threshold), 32'h1f);
        host.wr(8'h20, 32'h1, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        host.rd(8'h20, rdv, rsp);
        chk(rdv, 32'h0);
        chk(32'(rsp), 32'(RESP_SLVERR));
        $display("test registers done");
        summarize();
    end
endmodule
